// ===== rtl/tt2_edge_sync.v
`timescale 1ns/1ps
// ==========================================
// three-stage synchroniser; falling and rising events once stages 2 and 3 agree
module tt2_edge_sync (
  input wire clk_i,
  input wire rst_i,
  input wire pin_i,
  output reg fall_o,
  output reg rise_o
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg level_reg;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      level_reg <= 1'b1;
      fall_o <= 1'b0;
      rise_o <= 1'b0;
    end
    else
    begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      fall_o <= 1'b0;
      rise_o <= 1'b0;
      if (s2_reg == s3_reg && s3_reg != level_reg)
      begin
        level_reg <= s3_reg;
        fall_o <= ~s3_reg;
        rise_o <= s3_reg;
      end
    end
  end
endmodule // tt2_edge_sync

// ===== rtl/tt2_timer.v
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "tt2_map.vh"
// Contract
// - overflow sets flag unless UART clock bit set
// - enabled capture-pin fall sets external edge flag unless UART clock bit set
// - receive clock source selects this overflow
// - transmit clock source selects this overflow
// - pin enabled, UART bits clear: falls trigger
// - run bit starts and stops counting
// - timer mode counts every two clocks
// - counter mode counts pin or slow events
// - reload mode reloads on overflow, pin falls
// - capture mode captures count on pin falls
// - UART clock bits force overflow auto-reload
// - reload/capture bytes accessible, reset zero
// - count bytes readable, writable, reset zero
module tt2_timer (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire count_pin_i,
  input wire slow_clk_i,
  input wire slow_sel_i,
  input wire capture_pin_i,
  input wire timer1_ovf_i,
  output reg uart_rx_clk_o,
  output reg uart_tx_clk_o,
  output wire irq_o
);
  // ==========================================
  // registers
  reg overflow_flag_reg;
  reg external_edge_flag_reg;
  reg uart_rx_clock_source_reg;
  reg uart_tx_clock_source_reg;
  reg capture_pin_enable_reg;
  reg run_bit_reg;
  reg counter_timer_select_reg;
  reg capture_reload_select_reg;
  reg [7:0] reload_capture_low_reg;
  reg [7:0] reload_capture_high_reg;
  reg [7:0] count_low_reg;
  reg [7:0] count_high_reg;
  reg [2:0] irq_stat_reg;
  reg [2:0] irq_mask_reg;
  reg phase_reg;
  wire count_fall;
  wire slow_rise;
  wire cap_fall;
  wire [2:0] pin_bus = {capture_pin_i, slow_clk_i, count_pin_i};
  wire [2:0] fall_bus;
  wire [2:0] rise_bus;

  // ==========================================
  // pin synchronisers: bit 0 count pin, bit 1 slow clock, bit 2 capture pin
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_sync
      tt2_edge_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(pin_bus[gi]),
        .fall_o(fall_bus[gi]),
        .rise_o(rise_bus[gi])
      );
    end
  endgenerate

  assign count_fall = fall_bus[0];
  assign slow_rise = rise_bus[1];
  assign cap_fall = fall_bus[2];

  // ==========================================
  // bus decode
  // ack high blocks a second take of a request that is still held
  wire bus_req = cyc_i & stb_i & ~ack_o;
  wire bus_wr = bus_req & we_i & sel_i[0];
  wire bus_rd = bus_req & ~we_i;
  wire wr_ctrl = bus_wr & (adr_i == `TT2_ADR_CTRL);
  wire wr_rcl = bus_wr & (adr_i == `TT2_ADR_RCL);
  wire wr_rch = bus_wr & (adr_i == `TT2_ADR_RCH);
  wire wr_cntl = bus_wr & (adr_i == `TT2_ADR_CNTL);
  wire wr_cnth = bus_wr & (adr_i == `TT2_ADR_CNTH);
  wire wr_mask = bus_wr & (adr_i == `TT2_ADR_IRQ_MASK);
  wire rd_stat = bus_rd & (adr_i == `TT2_ADR_IRQ_STAT);

  // ==========================================
  // counting
  wire uart_mode = uart_rx_clock_source_reg | uart_tx_clock_source_reg;
  wire slow_event = slow_sel_i ? slow_rise : count_fall;
  wire tick = run_bit_reg & (counter_timer_select_reg ? slow_event : phase_reg);
  wire [15:0] count = {count_high_reg, count_low_reg};
  wire [15:0] reload = {reload_capture_high_reg, reload_capture_low_reg};
  wire [15:0] count_inc = count + 16'h0001;
  wire overflow = tick & (count == 16'hFFFF);
  // pin events are ignored while the uart owns the overflow
  wire pin_trig = capture_pin_enable_reg & ~uart_mode & cap_fall;
  wire capture_mode = capture_reload_select_reg & ~uart_mode;
  wire do_capture = pin_trig & capture_mode;
  wire do_reload = (overflow & ~capture_mode) | (pin_trig & ~capture_mode);
  reg [15:0] count_next;
  reg phase_next;

  always @*
  begin
    count_next = count;
    if (do_reload)
      count_next = reload;
    else if (tick)
      count_next = count_inc;
    // a software byte write wins over counting and reload
    if (wr_cntl)
      count_next[7:0] = dat_i[7:0];
    if (wr_cnth)
      count_next[15:8] = dat_i[7:0];
  end

  always @*
  begin
    phase_next = phase_reg;
    // phase only moves while running, so a stop keeps the alignment
    if (run_bit_reg)
      phase_next = phase_reg ^ `TT2_TIMER_DIV;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase_reg <= 1'b0;
      count_low_reg <= `TT2_RST_BYTE;
      count_high_reg <= `TT2_RST_BYTE;
    end
    else
    begin
      phase_reg <= phase_next;
      count_low_reg <= count_next[7:0];
      count_high_reg <= count_next[15:8];
    end
  end

  // ==========================================
  // control register next values
  reg overflow_flag_next;
  reg external_edge_flag_next;
  reg uart_rx_clock_source_next;
  reg uart_tx_clock_source_next;
  reg capture_pin_enable_next;
  reg run_bit_next;
  reg counter_timer_select_next;
  reg capture_reload_select_next;

  always @*
  begin
    overflow_flag_next = overflow_flag_reg;
    external_edge_flag_next = external_edge_flag_reg;
    uart_rx_clock_source_next = uart_rx_clock_source_reg;
    uart_tx_clock_source_next = uart_tx_clock_source_reg;
    capture_pin_enable_next = capture_pin_enable_reg;
    run_bit_next = run_bit_reg;
    counter_timer_select_next = counter_timer_select_reg;
    capture_reload_select_next = capture_reload_select_reg;
    if (wr_ctrl)
    begin
      overflow_flag_next = dat_i[`TT2_B_OVF];
      external_edge_flag_next = dat_i[`TT2_B_EXF];
      uart_rx_clock_source_next = dat_i[`TT2_B_RXCLK];
      uart_tx_clock_source_next = dat_i[`TT2_B_TXCLK];
      capture_pin_enable_next = dat_i[`TT2_B_PINEN];
      run_bit_next = dat_i[`TT2_B_RUN];
      counter_timer_select_next = dat_i[`TT2_B_CTSEL];
      capture_reload_select_next = dat_i[`TT2_B_CAPSEL];
    end
    // hardware set wins over a software write in the same cycle
    if (overflow & ~uart_mode)
      overflow_flag_next = 1'b1;
    if (pin_trig)
      external_edge_flag_next = 1'b1;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      overflow_flag_reg <= 1'b0;
      external_edge_flag_reg <= 1'b0;
      uart_rx_clock_source_reg <= 1'b0;
      uart_tx_clock_source_reg <= 1'b0;
      capture_pin_enable_reg <= 1'b0;
      run_bit_reg <= 1'b0;
      counter_timer_select_reg <= 1'b0;
      capture_reload_select_reg <= 1'b0;
    end
    else
    begin
      overflow_flag_reg <= overflow_flag_next;
      external_edge_flag_reg <= external_edge_flag_next;
      uart_rx_clock_source_reg <= uart_rx_clock_source_next;
      uart_tx_clock_source_reg <= uart_tx_clock_source_next;
      capture_pin_enable_reg <= capture_pin_enable_next;
      run_bit_reg <= run_bit_next;
      counter_timer_select_reg <= counter_timer_select_next;
      capture_reload_select_reg <= capture_reload_select_next;
    end
  end

  // ==========================================
  // reload/capture bytes
  reg [7:0] reload_capture_low_next;
  reg [7:0] reload_capture_high_next;

  always @*
  begin
    reload_capture_low_next = reload_capture_low_reg;
    reload_capture_high_next = reload_capture_high_reg;
    if (wr_rcl)
      reload_capture_low_next = dat_i[7:0];
    if (wr_rch)
      reload_capture_high_next = dat_i[7:0];
    // a capture wins over a software write in the same cycle
    if (do_capture)
    begin
      reload_capture_low_next = count_low_reg;
      reload_capture_high_next = count_high_reg;
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      reload_capture_low_reg <= `TT2_RST_BYTE;
      reload_capture_high_reg <= `TT2_RST_BYTE;
    end
    else
    begin
      reload_capture_low_reg <= reload_capture_low_next;
      reload_capture_high_reg <= reload_capture_high_next;
    end
  end

  // ==========================================
  // uart bit clocks
  reg uart_rx_next;
  reg uart_tx_next;

  always @*
  begin
    uart_rx_next = timer1_ovf_i;
    uart_tx_next = timer1_ovf_i;
    if (uart_rx_clock_source_reg)
      uart_rx_next = overflow;
    if (uart_tx_clock_source_reg)
      uart_tx_next = overflow;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      uart_rx_clk_o <= 1'b0;
      uart_tx_clk_o <= 1'b0;
    end
    else
    begin
      uart_rx_clk_o <= uart_rx_next;
      uart_tx_clk_o <= uart_tx_next;
    end
  end

  // ==========================================
  // interrupts: sticky status cleared by read, set wins
  wire [2:0] irq_set = {do_capture, pin_trig, overflow & ~uart_mode};
  reg [2:0] irq_stat_next;

  always @*
  begin
    irq_stat_next = irq_stat_reg;
    // a read clears, an event in the same cycle still sets
    if (rd_stat)
      irq_stat_next = 3'h0;
    irq_stat_next = irq_stat_next | irq_set;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_stat_reg <= `TT2_RST_IRQ;
      irq_mask_reg <= `TT2_RST_IRQ;
    end
    else
    begin
      irq_stat_reg <= irq_stat_next;
      if (wr_mask)
        irq_mask_reg <= dat_i[2:0];
    end
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // ==========================================
  // read data select
  reg [31:0] rd_data_next;

  always @*
  begin
    rd_data_next = 32'h00000000;
    case (adr_i)
      `TT2_ADR_CTRL: rd_data_next = {24'h000000, overflow_flag_reg, external_edge_flag_reg,
        uart_rx_clock_source_reg, uart_tx_clock_source_reg, capture_pin_enable_reg,
        run_bit_reg, counter_timer_select_reg, capture_reload_select_reg};
      `TT2_ADR_RCL: rd_data_next = {24'h000000, reload_capture_low_reg};
      `TT2_ADR_RCH: rd_data_next = {24'h000000, reload_capture_high_reg};
      `TT2_ADR_CNTL: rd_data_next = {24'h000000, count_low_reg};
      `TT2_ADR_CNTH: rd_data_next = {24'h000000, count_high_reg};
      `TT2_ADR_IRQ_STAT: rd_data_next = {29'h00000000, irq_stat_reg};
      `TT2_ADR_IRQ_MASK: rd_data_next = {29'h00000000, irq_mask_reg};
      default: rd_data_next = 32'h00000000;
    endcase
  end

  // ==========================================
  // bus answer: one wait state, registered data
  always @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= bus_req;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h00000000;
    else if (bus_rd)
      dat_o <= rd_data_next;
  end
endmodule // tt2_timer

// ===== shared/tt2_map.vh
`ifndef TT2_MAP_VH
`define TT2_MAP_VH
// ==========================================
// register byte addresses (byte index = offset, not all word aligned)
`define TT2_ADR_CTRL 8'hC8
`define TT2_ADR_RCL 8'hCA
`define TT2_ADR_RCH 8'hCB
`define TT2_ADR_CNTL 8'hCC
`define TT2_ADR_CNTH 8'hCD
`define TT2_ADR_IRQ_STAT 8'hD0
`define TT2_ADR_IRQ_MASK 8'hD4
// ==========================================
// control register fields
`define TT2_B_OVF 7
`define TT2_B_EXF 6
`define TT2_B_RXCLK 5
`define TT2_B_TXCLK 4
`define TT2_B_PINEN 3
`define TT2_B_RUN 2
`define TT2_B_CTSEL 1
`define TT2_B_CAPSEL 0
// ==========================================
// interrupt status fields
`define TT2_I_OVF 0
`define TT2_I_EXF 1
`define TT2_I_CAP 2
// ==========================================
// reset values
`define TT2_RST_CTRL 8'h00
`define TT2_RST_BYTE 8'h00
`define TT2_RST_IRQ 3'h0
// ==========================================
// timing: timer mode advances once per two system clocks
`define TT2_TIMER_DIV 1'h1
`endif

// ===== testbench/timer_two_capture_reload_tb.sv
`timescale 1ns/1ps
`include "tt2_map.vh"
module timer_two_capture_reload_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic fire = 1'b0;
  logic cnt_pin = 1'b1;
  logic slow_clk = 1'b0;
  logic slow_sel = 1'b0;
  wire uart_rx, uart_tx;
  int rx_n = 0;
  int tx_n = 0;
  logic [31:0] rd;
  wire [31:0] dat_o;
  wire ack_o, cap_pin, t1_ovf, irq_o;
  int failures = 0;
  int comparisons = 0;
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  tt2_timer i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .count_pin_i(cnt_pin), .slow_clk_i(slow_clk), .slow_sel_i(slow_sel),
    .capture_pin_i(cap_pin), .timer1_ovf_i(t1_ovf),
    .uart_rx_clk_o(uart_rx), .uart_tx_clk_o(uart_tx), .irq_o(irq_o)
  );
  tt2_far_end i_far (.clk_i(clk_i), .fire_i(fire), .capture_pin_o(cap_pin), .t1_ovf_o(t1_ovf));
  // pulse counters on the uart bit clocks
  always @(posedge clk_i)
  begin
    if (uart_rx)
      rx_n <= rx_n + 1;
    if (uart_tx)
      tx_n <= tx_n + 1;
  end
  // ==========================================
  // bus and check helpers
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'h1, 24'h0, d};
    do
    begin
      @(posedge clk_i);
    end
    while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk(rd, {24'h0, exp});
  endtask
  task automatic pulse();
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    rdchk(`TT2_ADR_CTRL, 8'h00);
    rdchk(`TT2_ADR_RCL, 8'h00);
    rdchk(`TT2_ADR_RCH, 8'h00);
    rdchk(`TT2_ADR_CNTL, 8'h00);
    rdchk(`TT2_ADR_CNTH, 8'h00);
    wb(1'b1, 8'hC9, 8'h5A);
    rdchk(8'hC9, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_count();
    wb(1'b1, `TT2_ADR_CNTL, 8'h0F);
    wb(1'b1, `TT2_ADR_CNTH, 8'hA5);
    wb(1'b1, `TT2_ADR_CTRL, 8'h04);
    repeat (40) @(posedge clk_i);
    wb(1'b1, `TT2_ADR_CTRL, 8'h00);
    wb(1'b0, `TT2_ADR_CNTL, 8'h00);
    chk(rd, 32'h24);
    repeat (20) @(posedge clk_i);
    wb(1'b0, `TT2_ADR_CNTL, 8'h00);
    chk(rd, 32'h24);
    rdchk(`TT2_ADR_CNTH, 8'hA5);
    $display("count test done");
  endtask
  task automatic t_reload();
    wb(1'b1, `TT2_ADR_RCL, 8'h34);
    wb(1'b1, `TT2_ADR_RCH, 8'h12);
    wb(1'b1, `TT2_ADR_CNTL, 8'hFE);
    wb(1'b1, `TT2_ADR_CNTH, 8'hFF);
    wb(1'b1, `TT2_ADR_CTRL, 8'h04);
    repeat (10) @(posedge clk_i);
    rdchk(`TT2_ADR_CTRL, 8'h84);
    wb(1'b1, `TT2_ADR_CTRL, 8'h00);
    rdchk(`TT2_ADR_CNTH, 8'h12);
    rdchk(`TT2_ADR_CTRL, 8'h00);
    chk({31'h0, irq_o}, 32'h0);
    wb(1'b1, `TT2_ADR_IRQ_MASK, 8'h01);
    chk({31'h0, irq_o}, 32'h1);
    rdchk(`TT2_ADR_IRQ_STAT, 8'h01);
    chk({31'h0, irq_o}, 32'h0);
    $display("reload test done");
  endtask
  task automatic t_capture();
    logic [7:0] ign [3] = '{8'h05, 8'h1D, 8'h2D};
    wb(1'b1, `TT2_ADR_CNTL, 8'h00);
    wb(1'b1, `TT2_ADR_CNTH, 8'h56);
    foreach (ign[i])
    begin
      wb(1'b1, `TT2_ADR_CTRL, ign[i]);
      pulse();
      rdchk(`TT2_ADR_CTRL, ign[i]);
      rdchk(`TT2_ADR_RCH, 8'h12);
    end
    wb(1'b1, `TT2_ADR_CTRL, 8'h0D);
    pulse();
    rdchk(`TT2_ADR_CTRL, 8'h4D);
    rdchk(`TT2_ADR_RCH, 8'h56);
    $display("capture test done");
  endtask
  task automatic t_uart();
    int r0;
    int t0;
    wb(1'b1, `TT2_ADR_CTRL, 8'h00);
    wb(1'b1, `TT2_ADR_CNTL, 8'hFE);
    wb(1'b1, `TT2_ADR_CNTH, 8'hFF);
    wb(1'b1, `TT2_ADR_CTRL, 8'h35);
    @(posedge clk_i);
    r0 = rx_n;
    t0 = tx_n;
    repeat (10) @(posedge clk_i);
    chk(rx_n - r0, 32'h1);
    chk(tx_n - t0, 32'h1);
    rdchk(`TT2_ADR_CTRL, 8'h35);
    rdchk(`TT2_ADR_CNTH, 8'h56);
    wb(1'b1, `TT2_ADR_CTRL, 8'h00);
    $display("uart clock test done");
  endtask
  task automatic t_counter();
    wb(1'b1, `TT2_ADR_CNTL, 8'h00);
    wb(1'b1, `TT2_ADR_CNTH, 8'h00);
    wb(1'b1, `TT2_ADR_CTRL, 8'h06);
    repeat (3)
    begin
      cnt_pin <= 1'b0;
      repeat (6) @(posedge clk_i);
      cnt_pin <= 1'b1;
      repeat (6) @(posedge clk_i);
    end
    slow_sel <= 1'b1;
    repeat (2)
    begin
      slow_clk <= 1'b1;
      repeat (6) @(posedge clk_i);
      slow_clk <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
    wb(1'b1, `TT2_ADR_CTRL, 8'h00);
    rdchk(`TT2_ADR_CNTL, 8'h05);
    rdchk(`TT2_ADR_CNTH, 8'h00);
    $display("counter test done");
  endtask
  task automatic results();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    results();
  end
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_count();
    t_reload();
    t_capture();
    t_uart();
    t_counter();
    results();
  end
endmodule // timer_two_capture_reload_tb

// ===== testbench/tt2_far_end.sv
`timescale 1ns/1ps
// ==========================================
// capture pin with pull-up and the other timer's overflow pulses
module tt2_far_end (
  input wire clk_i,
  input wire fire_i,
  output logic capture_pin_o,
  output logic t1_ovf_o
);
  int low_cnt = 0;
  int div = 0;
  always @(posedge clk_i)
  begin
    div <= (div + 1) % 16;
    low_cnt <= fire_i ? 6 : (low_cnt > 0 ? low_cnt - 1 : 0);
  end
  assign capture_pin_o = (low_cnt == 0);
  assign t1_ovf_o = (div == 15);
endmodule // tt2_far_end

// ===== testbench/tt2_timer_monitor.sv
`timescale 1ns/1ps
`include "tt2_map.vh"
module tt2_timer_monitor (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire timer1_ovf_i,
  input wire uart_rx_clk_o,
  input wire uart_tx_clk_o,
  input wire irq_o
);
  logic [1:0] src_reg;
  logic [2:0] mask_reg;
  wire take_wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  wire hole = (adr_i == 8'hC9) || (adr_i == 8'hCE);
  // ==========================================
  // shadows of the clock source bits and the mask
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      src_reg <= 2'h0;
      mask_reg <= 3'h0;
    end
    else if (take_wr && adr_i == `TT2_ADR_CTRL)
      src_reg <= dat_i[5:4];
    else if (take_wr && adr_i == `TT2_ADR_IRQ_MASK)
      mask_reg <= dat_i[2:0];
  end
  // ==========================================
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ans;
    ack_o ##1 !ack_o;
  endsequence
  AST_ACK_ONE: assert property (s_req |=> s_ans)
    else $error("ack not a single pulse one cycle after request");
  AST_ACK_CAUSE: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  AST_DAT_HOLD: assert property (!ack_o |-> $stable(dat_o))
    else $error("read data changed without answer");
  AST_HOLE_ZERO: assert property (cyc_i && stb_i && !ack_o && !we_i && hole |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_RX_T1: assert property (!src_reg[1] |=> uart_rx_clk_o == $past(timer1_ovf_i))
    else $error("receive clock not from other timer");
  AST_TX_T1: assert property (!src_reg[0] |=> uart_tx_clk_o == $past(timer1_ovf_i))
    else $error("transmit clock not from other timer");
  AST_IRQ_MASK: assert property (mask_reg == 3'h0 |-> !irq_o)
    else $error("interrupt while fully masked");
  AST_RST_QUIET: assert property ($fell(rst_i) |-> !irq_o && !ack_o && dat_o == 32'h0)
    else $error("outputs not idle after reset");
endmodule // tt2_timer_monitor

bind tt2_timer tt2_timer_monitor i_mon (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .timer1_ovf_i(timer1_ovf_i), .uart_rx_clk_o(uart_rx_clk_o),
  .uart_tx_clk_o(uart_tx_clk_o), .irq_o(irq_o)
);
